// File: design/diag_seq_map.vh
// constants shared by the diagnostic sequencer files
// assumes a 250 MHz system clock
`ifndef DIAG_SEQ_MAP_VH
`define DIAG_SEQ_MAP_VH

// register byte offsets
`define ENTRY_OFFSET 4'h0
`define STATUS_OFFSET 4'h4
`define LOOP_OFFSET 4'h8

// entry register fields
`define ENTRY_DIGITS_HI 15
`define ENTRY_SIGN_BIT 16
`define ENTRY_DP_LO 17
`define ENTRY_DP_HI 18
`define ENTRY_RESET 19'h00000

// display character codes
`define CHAR_MINUS 4'ha
`define CHAR_E 4'hb
`define CHAR_H 4'hc
`define CHAR_L 4'hd
`define CHAR_P 4'he
`define CHAR_BLANK 4'hf
`define CHAR_LAST 4'he

// reserved code digits: -59x.x
`define DIAG_HUNDREDS 4'h5
`define DIAG_TENS 4'h9
`define SEL_EXERCISE 8'h40
`define SEL_WATCHDOG 8'h20
`define SEL_HANDSHAKE 8'h02
`define LSD_FAST 4'h1
`define LSD_EXIT 4'h9

// decimal point positions (one-hot value of the dp output)
`define DP_TENTHS 4'h2
`define DP_THOUSANDTHS 4'h8
`define DP_UNITS 4'h1

// loop output
`define LOOP_MAX 14'h0fff
`define LOOP_FULL 12'hfff
`define LOOP_RESET 12'h000

// timing
`define CLOCK_MHZ 250
`define WDOG_TIME_MS 4000
`define STEP_TIME_MS 200
`define FAST_DIVIDE 8
`define WDOG_CYCLES (`WDOG_TIME_MS * 1000 * `CLOCK_MHZ)
`define STEP_CYCLES (`STEP_TIME_MS * 1000 * `CLOCK_MHZ)

`endif

// File: design/pin_sync.v
// three-stage synchroniser for one pin input
// assumes the pin is asynchronous to CLOCK
`timescale 1ns/100ps
module pin_sync (
    input wire clock,
    input wire reset,
    input wire pin,
    output reg level
);
    reg s1;
    reg s2;
    reg s3;

    always @(posedge clock) begin
        if (reset) begin
            s1 <= 1'b0;
            s2 <= 1'b0;
            s3 <= 1'b0;
            level <= 1'b0;
        end else begin
            s1 <= pin;
            s2 <= s1;
            s3 <= s2;
            // a change counts once stages two and three agree
            if (s2 == s3) begin
                level <= s3;
            end
        end
    end
endmodule

// File: design/watchdog_timer.v
// watchdog: expires when not kicked for the full timeout
// assumes kick comes from logic on the same clock
`timescale 1ns/100ps
module watchdog_timer #(
    parameter [31:0] TIMEOUT = 32'd1000000000
) (
    input wire clock,
    input wire reset,
    input wire kick,
    output reg expire
);
    reg [31:0] count;

    always @(posedge clock) begin
        if (reset) begin
            count <= 32'h00000000;
            expire <= 1'b0;
        end else if (kick || expire) begin
            count <= 32'h00000000;
            expire <= 1'b0;
        end else if (count >= TIMEOUT - 32'd1) begin
            count <= 32'h00000000;
            expire <= 1'b1;
        end else begin
            count <= count + 32'd1;
        end
    end
endmodule

// File: design/controller_diagnostic_sequencer.v
// diagnostic test sequencer of a stand-alone process controller
// assumes software writes operator entries over the plain register port,
// and handshake and loop-select pins arrive asynchronously
`timescale 1ns/100ps
`include "diag_seq_map.vh"
module controller_diagnostic_sequencer #(
    parameter [31:0] WDOG_CYCLES = `WDOG_CYCLES,
    parameter [31:0] STEP_CYCLES = `STEP_CYCLES
) (
    input wire CLOCK,
    input wire RESET,
    input wire [3:0] ADDRESS,
    input wire [31:0] WRITE_DATA,
    input wire WRITE_STROBE,
    input wire READ_STROBE,
    output reg [31:0] READ_DATA,
    input wire READ_TEMP_REQUEST,
    input wire SETPOINT_VALID_STROBE,
    input wire LOOP_SELECT,
    output reg [15:0] SETPOINT_DISPLAY,
    output reg [15:0] MEASURED_DISPLAY,
    output reg [3:0] DECIMAL_POINT,
    output reg HEAT,
    output reg COOL,
    output reg AUX,
    output reg INCREASE_LED,
    output reg DECREASE_LED,
    output reg [11:0] LOOP_OUTPUT,
    output reg WATCHDOG_RESET
);
    localparam [5:0] S_IDLE = 6'h01;
    localparam [5:0] S_CHARS = 6'h02;
    localparam [5:0] S_DOTS = 6'h04;
    localparam [5:0] S_OUTS = 6'h08;
    localparam [5:0] S_STATUS = 6'h10;
    localparam [5:0] S_WDOG = 6'h20;
    localparam [31:0] FAST_CYCLES = STEP_CYCLES / `FAST_DIVIDE;

    reg [5:0] state;
    reg [18:0] entry;
    reg [3:0] step;
    reg [31:0] step_count;
    reg fast;
    reg power_up;
    reg kick;
    reg [15:0] normal_display;
    reg [3:0] normal_dp;
    wire expire;
    wire rst;
    wire [2:0] pin_level;
    wire read_temp;
    wire setpoint_valid_strobe;
    wire loop_absent;
    wire step_tick;
    wire write_entry;
    wire [18:0] new_entry;
    wire [3:0] char_now;
    wire state_legal;

    // watchdog expiry takes the block, all but the pin synchronisers, back to its start state
    assign rst = RESET | expire;
    assign read_temp = pin_level[0];
    assign setpoint_valid_strobe = pin_level[1];
    assign loop_absent = pin_level[2];
    assign write_entry = WRITE_STROBE && (ADDRESS == `ENTRY_OFFSET);
    assign new_entry = WRITE_DATA[18:0];
    assign step_tick = step_count >= ((fast ? FAST_CYCLES : STEP_CYCLES) - 32'd1);
    assign char_now = step;
    assign state_legal = (state == S_IDLE) || (state == S_CHARS) || (state == S_DOTS) ||
                         (state == S_OUTS) || (state == S_STATUS) || (state == S_WDOG);

    genvar g;
    generate
        for (g = 0; g < 3; g = g + 1) begin : sync
            pin_sync u_sync (
                .clock(CLOCK),
                .reset(RESET),
                .pin(g == 0 ? READ_TEMP_REQUEST : (g == 1 ? SETPOINT_VALID_STROBE : LOOP_SELECT)),
                .level(pin_level[g])
            );
        end
    endgenerate

    watchdog_timer #(
        .TIMEOUT(WDOG_CYCLES)
    ) u_wdog (
        .clock(CLOCK),
        .reset(RESET),
        .kick(kick),
        .expire(expire)
    );

    // true for the reserved -59x.x code series
    function is_diag;
        input [18:0] e;
        begin
            is_diag = e[`ENTRY_SIGN_BIT] && (e[15:12] == `DIAG_HUNDREDS) &&
                      (e[11:8] == `DIAG_TENS);
        end
    endfunction

    // level shown as the letter H or L
    function [3:0] hl;
        input b;
        begin
            hl = b ? `CHAR_H : `CHAR_L;
        end
    endfunction

    // four bcd digits to binary, clamped to the loop range
    function [11:0] loop_value;
        input [15:0] d;
        reg [13:0] v;
        begin
            v = {10'h000, d[15:12]} * 14'd1000 + {10'h000, d[11:8]} * 14'd100 +
                {10'h000, d[7:4]} * 14'd10 + {10'h000, d[3:0]};
            loop_value = (v > `LOOP_MAX) ? `LOOP_FULL : v[11:0];
        end
    endfunction

    // all four digits showing one character, leading digit never zero
    function [15:0] all_char;
        input [3:0] c;
        begin
            all_char = {(c == 4'h0) ? `CHAR_BLANK : c, c, c, c};
        end
    endfunction

    always @(posedge CLOCK) begin
        if (rst) begin
            state <= S_CHARS;
            entry <= `ENTRY_RESET;
            step <= 4'h0;
            step_count <= 32'h00000000;
            fast <= 1'b0;
            power_up <= 1'b1;
            kick <= 1'b0;
            normal_display <= {4{`CHAR_BLANK}};
            normal_dp <= 4'h0;
            READ_DATA <= 32'h00000000;
            SETPOINT_DISPLAY <= all_char(4'h0);
            MEASURED_DISPLAY <= all_char(4'h0);
            DECIMAL_POINT <= 4'h0;
            HEAT <= 1'b0;
            COOL <= 1'b0;
            AUX <= 1'b0;
            INCREASE_LED <= 1'b0;
            DECREASE_LED <= 1'b0;
            LOOP_OUTPUT <= `LOOP_RESET;
            // expiry itself forces this branch, so the flag is raised here
            WATCHDOG_RESET <= expire;
        end else begin
            WATCHDOG_RESET <= 1'b0;
            // an unknown state drops the kick for one cycle; the default branch returns it to S_IDLE
            kick <= state_legal && (state != S_WDOG);

            if (READ_STROBE) begin
                if (ADDRESS == `ENTRY_OFFSET) begin
                    READ_DATA <= {13'h0000, entry};
                end else if (ADDRESS == `STATUS_OFFSET) begin
                    READ_DATA <= {16'h0000, power_up, fast, step, loop_absent,
                                  setpoint_valid_strobe, read_temp, 1'b0, state};
                end else if (ADDRESS == `LOOP_OFFSET) begin
                    READ_DATA <= {20'h00000, LOOP_OUTPUT};
                end else begin
                    READ_DATA <= 32'h00000000;
                end
            end else begin
                READ_DATA <= 32'h00000000;
            end

            if (step_tick) begin
                step_count <= 32'h00000000;
            end else begin
                step_count <= step_count + 32'd1;
            end

            case (state)
                S_IDLE: begin
                    SETPOINT_DISPLAY <= entry[15:0];
                    MEASURED_DISPLAY <= normal_display;
                    DECIMAL_POINT <= normal_dp;
                    HEAT <= 1'b0;
                    COOL <= 1'b0;
                    AUX <= 1'b0;
                    INCREASE_LED <= 1'b0;
                    DECREASE_LED <= 1'b0;
                    if (write_entry) begin
                        entry <= new_entry;
                        step <= 4'h0;
                        step_count <= 32'h00000000;
                        fast <= 1'b0;
                        if (!is_diag(new_entry)) begin
                            normal_display <= new_entry[15:0];
                            normal_dp <= 4'h1 << new_entry[`ENTRY_DP_HI:`ENTRY_DP_LO];
                            if (!loop_absent) begin
                                LOOP_OUTPUT <= loop_value(new_entry[15:0]);
                            end
                        end else if (new_entry[7:0] == `SEL_EXERCISE) begin
                            state <= S_CHARS;
                        end else if (new_entry[7:0] == `SEL_WATCHDOG) begin
                            state <= S_WDOG;
                        end else if (new_entry[7:0] == `SEL_HANDSHAKE) begin
                            state <= S_STATUS;
                        end
                    end
                end
                S_CHARS: begin
                    SETPOINT_DISPLAY <= all_char(char_now);
                    MEASURED_DISPLAY <= all_char(char_now);
                    DECIMAL_POINT <= 4'h0;
                    if (step_tick) begin
                        if (step == `CHAR_LAST) begin
                            step <= 4'h0;
                            // at power-up only the digit cycle runs
                            state <= power_up ? S_IDLE : S_DOTS;
                            power_up <= 1'b0;
                        end else begin
                            step <= step + 4'h1;
                        end
                    end
                end
                S_DOTS: begin
                    SETPOINT_DISPLAY <= {4{`CHAR_BLANK}};
                    MEASURED_DISPLAY <= {4{`CHAR_BLANK}};
                    if (step == 4'h0) begin
                        DECIMAL_POINT <= `DP_TENTHS;
                    end else if (step == 4'h1) begin
                        DECIMAL_POINT <= `DP_THOUSANDTHS;
                    end else begin
                        DECIMAL_POINT <= `DP_UNITS;
                    end
                    if (step_tick) begin
                        if (step == 4'h2) begin
                            step <= 4'h0;
                            state <= S_OUTS;
                        end else begin
                            step <= step + 4'h1;
                        end
                    end
                end
                S_OUTS: begin
                    DECIMAL_POINT <= 4'h0;
                    HEAT <= (step == 4'h0);
                    INCREASE_LED <= (step == 4'h0);
                    COOL <= (step == 4'h1);
                    DECREASE_LED <= (step == 4'h1);
                    AUX <= (step == 4'h2);
                    if (step_tick) begin
                        if (step == 4'h2) begin
                            step <= 4'h0;
                            state <= S_IDLE;
                        end else begin
                            step <= step + 4'h1;
                        end
                    end
                end
                S_STATUS: begin
                    SETPOINT_DISPLAY <= entry[15:0];
                    MEASURED_DISPLAY <= {hl(read_temp), hl(setpoint_valid_strobe),
                                         hl(loop_absent), `CHAR_BLANK};
                    DECIMAL_POINT <= 4'h0;
                    if (write_entry) begin
                        entry <= new_entry;
                        state <= S_IDLE;
                    end
                end
                S_WDOG: begin
                    // kicks stay off here until the watchdog takes the block back
                    SETPOINT_DISPLAY <= entry[15:0];
                    MEASURED_DISPLAY <= {4{`CHAR_BLANK}};
                    DECIMAL_POINT <= 4'h0;
                end
                default: begin
                    state <= S_IDLE;
                end
            endcase

            // operator entries while the exercise runs
            if (write_entry && ((state == S_CHARS) || (state == S_DOTS) ||
                                (state == S_OUTS)) && !power_up) begin
                if (new_entry[3:0] == `LSD_FAST) begin
                    fast <= 1'b1;
                end else if (new_entry[3:0] == `LSD_EXIT) begin
                    state <= S_IDLE;
                    step <= 4'h0;
                    HEAT <= 1'b0;
                    COOL <= 1'b0;
                    AUX <= 1'b0;
                    INCREASE_LED <= 1'b0;
                    DECREASE_LED <= 1'b0;
                end
            end
        end
    end
endmodule

// File: dv/diag_seq_monitor.sv
// port checker for the diagnostic sequencer
// assumes it is bound to the sequencer top module
`timescale 1ns/100ps
module diag_seq_monitor (
    input wire CLOCK,
    input wire RESET,
    input wire READ_STROBE,
    input wire [31:0] READ_DATA,
    input wire [15:0] SETPOINT_DISPLAY,
    input wire [3:0] DECIMAL_POINT,
    input wire HEAT,
    input wire COOL,
    input wire AUX,
    input wire INCREASE_LED,
    input wire DECREASE_LED,
    input wire [11:0] LOOP_OUTPUT,
    input wire WATCHDOG_RESET
);
    default clocking cb @(posedge CLOCK); endclocking
    default disable iff (RESET);
    AST_HEAT_LED: assert property (INCREASE_LED == HEAT)
        else $error("increase led differs from heat");
    AST_COOL_LED: assert property (DECREASE_LED == COOL)
        else $error("decrease led differs from cool");
    AST_AUX_ALONE: assert property (AUX |-> !(HEAT || COOL || INCREASE_LED || DECREASE_LED))
        else $error("aux pulse overlaps another output");
    AST_COOL_AFTER_HEAT: assert property ($rose(COOL) |-> $past(HEAT))
        else $error("cool did not follow heat");
    AST_AUX_AFTER_COOL: assert property ($rose(AUX) |-> $past(COOL))
        else $error("aux did not follow cool");
    AST_HEAT_AFTER_UNITS: assert property ($rose(HEAT) |-> $past(DECIMAL_POINT) == 4'h1)
        else $error("heat did not follow units point");
    AST_DP_ONE: assert property ($onehot0(DECIMAL_POINT))
        else $error("more than one decimal point lit");
    AST_WDOG_PULSE: assert property (WATCHDOG_RESET |=> !WATCHDOG_RESET)
        else $error("watchdog reset longer than one cycle");
    AST_WDOG_START: assert property (WATCHDOG_RESET |-> ##[0:2]
        (SETPOINT_DISPLAY == 16'hf000 && LOOP_OUTPUT == 12'h000 && !HEAT))
        else $error("watchdog expiry did not restore start state");
    AST_READ_QUIET: assert property (!$past(READ_STROBE) |-> READ_DATA == 32'h0)
        else $error("read data outside its cycle");
endmodule
bind controller_diagnostic_sequencer diag_seq_monitor mon_u (.CLOCK(CLOCK), .RESET(RESET),
    .READ_STROBE(READ_STROBE), .READ_DATA(READ_DATA), .SETPOINT_DISPLAY(SETPOINT_DISPLAY),
    .DECIMAL_POINT(DECIMAL_POINT), .HEAT(HEAT), .COOL(COOL), .AUX(AUX),
    .INCREASE_LED(INCREASE_LED), .DECREASE_LED(DECREASE_LED), .LOOP_OUTPUT(LOOP_OUTPUT),
    .WATCHDOG_RESET(WATCHDOG_RESET));

// File: dv/panel_host_model.sv
// host handshake and loop-select pins seen by the sequencer
// assumes the bench requests levels; pins move away from the clock edge
`timescale 1ns/100ps
module panel_host_model (
    input wire clock,
    input wire [2:0] levels,
    output reg read_temp,
    output reg setpoint_valid,
    output reg loop_select
);
    initial {read_temp, setpoint_valid, loop_select} = 3'b000;
    // pins are asynchronous to the sequencer, so they move mid-cycle
    always @(posedge clock) begin
        #1.3 {read_temp, setpoint_valid, loop_select} <= levels;
    end
endmodule

// File: dv/controller_diagnostic_sequencer_tb.sv
// self-checking bench for the diagnostic sequencer
// assumes short step and watchdog counts set at the instance
`timescale 1ns/100ps
module controller_diagnostic_sequencer_tb;
    localparam [31:0] WDOG = 32'd200;
    localparam [31:0] STEP = 32'd16;
    reg clock = 1'b0;
    reg reset = 1'b1;
    reg [3:0] address = 4'h0;
    reg [31:0] write_data = 32'h0;
    reg write_strobe = 1'b0;
    reg read_strobe = 1'b0;
    reg [2:0] levels = 3'b000;
    wire [31:0] read_data;
    wire read_temp, setpoint_valid, loop_select, heat, cool, aux;
    wire increase_led, decrease_led, watchdog_reset;
    wire [15:0] setpoint_display, measured_display;
    wire [3:0] decimal_point;
    wire [11:0] loop_output;
    integer mismatches = 0;
    integer tests_run = 0;
    integer i, n;
    reg [31:0] d;
    // address, entry, echoed digits, loop code, decimal point
    reg [55:0] rows [0:5] = '{{4'h0, 20'h00000, 16'h0000, 12'h000, 4'h1},
        {4'h0, 20'h04095, 16'h4095, 12'hfff, 4'h1}, {4'h0, 20'h22047, 16'h2047, 12'h7ff, 4'h2},
        {4'h4, 20'h01234, 16'h2047, 12'h7ff, 4'h2}, {4'h0, 20'h05940, 16'h5940, 12'hfff, 4'h1},
        {4'h0, 20'h61000, 16'h1000, 12'h3e8, 4'h8}};
    controller_diagnostic_sequencer #(.WDOG_CYCLES(WDOG), .STEP_CYCLES(STEP)) dut_u (
        .CLOCK(clock), .RESET(reset), .ADDRESS(address), .WRITE_DATA(write_data),
        .WRITE_STROBE(write_strobe), .READ_STROBE(read_strobe), .READ_DATA(read_data),
        .READ_TEMP_REQUEST(read_temp), .SETPOINT_VALID_STROBE(setpoint_valid),
        .LOOP_SELECT(loop_select), .SETPOINT_DISPLAY(setpoint_display),
        .MEASURED_DISPLAY(measured_display), .DECIMAL_POINT(decimal_point), .HEAT(heat),
        .COOL(cool), .AUX(aux), .INCREASE_LED(increase_led), .DECREASE_LED(decrease_led),
        .LOOP_OUTPUT(loop_output), .WATCHDOG_RESET(watchdog_reset));
    panel_host_model model_u (.clock(clock), .levels(levels), .read_temp(read_temp),
        .setpoint_valid(setpoint_valid), .loop_select(loop_select));
    always #2 clock = ~clock;
    function [3:0] hl(input b);
        hl = b ? 4'hc : 4'hd;
    endfunction
    task check(input string what, input [31:0] seen, input [31:0] exp);
        begin
            tests_run = tests_run + 1;
            if (seen !== exp) begin
                mismatches = mismatches + 1;
                $display("ERROR %s expected %h seen %h", what, exp, seen);
            end
        end
    endtask
    task wr(input [3:0] a, input [31:0] v);
        begin
            @(posedge clock);
            address <= a;
            write_data <= v;
            write_strobe <= 1'b1;
            @(posedge clock);
            write_strobe <= 1'b0;
        end
    endtask
    task rd(input [3:0] a);
        begin
            @(posedge clock);
            address <= a;
            read_strobe <= 1'b1;
            @(posedge clock);
            read_strobe <= 1'b0;
            #1 d = read_data;
        end
    endtask
    task wait_state(input [5:0] st);
        begin
            n = 0;
            rd(4'h4);
            while (d[5:0] !== st && n < 600) begin
                rd(4'h4);
                n = n + 1;
            end
            check("state", {26'h0, d[5:0]}, {26'h0, st});
        end
    endtask
    task wait_dp(input [3:0] from);
        begin
            n = 0;
            while (decimal_point === from && n < 200) begin
                @(negedge clock);
                n = n + 1;
            end
        end
    endtask
    task report_and_stop;
        begin
            if (mismatches == 0 && tests_run > 0)
                $display("DONE - PASS");
            else
                $display("DONE - FAIL");
            $finish;
        end
    endtask
    initial begin
        #(4 * 30000);
        mismatches = mismatches + 1;
        report_and_stop;
    end
    initial begin
        repeat (8) @(posedge clock);
        check("reset display", {16'h0, measured_display}, 32'hf000);
        reset <= 1'b0;
        wait_state(6'h01);
        for (i = 0; i < 6; i = i + 1) begin
            wr(rows[i][55:52], {12'h0, rows[i][51:32]});
            repeat (3) @(posedge clock);
            check("echo", {16'h0, measured_display}, {16'h0, rows[i][31:16]});
            check("dp", {28'h0, decimal_point}, {28'h0, rows[i][3:0]});
            rd(4'h8);
            check("loop reg", d, {20'h0, rows[i][15:4]});
            check("loop pin", {20'h0, loop_output}, {20'h0, rows[i][15:4]});
        end
        rd(4'hc);
        check("unmapped", d, 32'h0);
        wr(4'h0, 32'h00015902);
        for (i = 0; i < 8; i = i + 1) begin
            levels <= i[2:0];
            repeat (8) @(posedge clock);
            check("status", {16'h0, measured_display},
                {16'h0, hl(i[2]), hl(i[1]), hl(i[0]), 4'hf});
        end
        levels <= 3'b000;
        wr(4'h0, 32'h00001234);
        wait_state(6'h01);
        wr(4'h0, 32'h00015940);
        repeat (2) @(negedge clock);
        check("first char", {setpoint_display, measured_display}, 32'hf000f000);
        wr(4'h0, 32'h00000001);
        rd(4'h4);
        check("fast", {31'h0, d[14]}, 32'h1);
        n = 0;
        while (setpoint_display !== 16'heeee && n < 2000) begin
            @(negedge clock);
            n = n + 1;
        end
        check("last char", {setpoint_display, measured_display}, 32'heeeeeeee);
        wait_dp(4'h0);
        check("dp tenths", {28'h0, decimal_point}, 32'h2);
        wait_dp(4'h2);
        check("dp thousandths", {28'h0, decimal_point}, 32'h8);
        wait_dp(4'h8);
        check("dp units", {28'h0, decimal_point}, 32'h1);
        n = 0;
        while (heat !== 1'b1 && n < 200) begin
            @(negedge clock);
            n = n + 1;
        end
        n = 0;
        while (heat === 1'b1 && n < 100) begin
            @(negedge clock);
            n = n + 1;
        end
        check("heat width", n, STEP / 8);
        check("cool", {28'h0, cool, decrease_led, aux, heat}, 32'hc);
        repeat (2) @(negedge clock);
        check("aux", {28'h0, cool, decrease_led, aux, increase_led}, 32'h2);
        wait_state(6'h01);
        wr(4'h0, 32'h00015940);
        wr(4'h0, 32'h00000009);
        repeat (3) @(posedge clock);
        rd(4'h4);
        check("exit", {26'h0, d[5:0]}, 32'h01);
        wr(4'h0, 32'h00015940);
        repeat (20) @(posedge clock);
        reset <= 1'b1;
        repeat (8) @(posedge clock);
        check("mid reset", {4'h0, loop_output, measured_display}, 32'hf000);
        reset <= 1'b0;
        wait_state(6'h01);
        wr(4'h0, 32'h00015920);
        n = 0;
        while (watchdog_reset !== 1'b1 && n < 1000) begin
            @(negedge clock);
            n = n + 1;
        end
        check("wdog time", {31'h0, (n >= WDOG - 4 && n <= WDOG + 8)}, 32'h1);
        rd(4'h4);
        check("power up", {31'h0, d[15]}, 32'h1);
        wait_state(6'h01);
        report_and_stop;
    end
endmodule
